// ===== verilog/cfp_params.svh
// Timing counts and constants for the converter fault protection block.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef CFP_PARAMS_SVH
`define CFP_PARAMS_SVH
`define CFP_CLK_NS          20
`define CFP_OC_TRIP         2'h3
`define CFP_HICCUP_PERIODS  3'h7
`define CFP_SYNC_LATE_NS    1000
`define CFP_SYNC_LATE_CYC   ((`CFP_SYNC_LATE_NS) / (`CFP_CLK_NS))
`define CFP_SS_CYC_DEF      4096
`define CFP_DISCH_CYC_DEF   64
`endif

// ===== verilog/cfp_pkg.sv
// Types shared by the converter fault protection files.
// Assumes cfp_params.svh supplies the numeric constants.
package cfp_pkg;
    typedef enum logic [2:0] {
        ST_SOFTSTART = 3'h0,
        ST_RUN       = 3'h1,
        ST_DISCHARGE = 3'h2,
        ST_HICCUP    = 3'h3,
        ST_THERMAL   = 3'h4
    } cfp_state_t;

    typedef struct packed {
        logic hsPeak;
        logic lsOver;
        logic lsNeg;
        logic overVolt;
        logic underVolt;
        logic overTemp;
        logic syncClk;
        logic shareLine;
    } cfp_flags_t;

    typedef struct packed {
        logic highOn;
        logic lowOn;
    } cfp_gate_t;
endpackage

// ===== verilog/cfp_sync_watch.sv
// Lost-synchronisation detector for the sync clock.
// Assumes syncIn is already synchronised to clk.
`timescale 1ns/1ps
`include "cfp_params.svh"
module cfp_sync_watch (
    input  wire logic clk,       // System clock
    input  wire logic reset,     // Synchronous, active high
    input  wire logic syncIn,    // Synchronised sync clock level
    input  wire logic enable,    // Sync mode active
    output logic      lostSync   // Sticky lost sync fault
);
    localparam logic [15:0] LATE = 16'(`CFP_SYNC_LATE_CYC);
    logic        syncPrev_q;
    logic [15:0] cnt_q;
    logic [15:0] prevPeriod_q;
    logic        primed_q;
    logic [1:0]  edges_q;
    wire         fallEdge = syncPrev_q & ~syncIn;
    wire  [16:0] limit    = {1'b0, prevPeriod_q} + {1'b0, LATE};
    wire         tooLate  = primed_q & ({1'b0, cnt_q} > limit);

    always_ff @(posedge clk) begin
        if (reset) begin
            syncPrev_q   <= 1'b0;
            cnt_q        <= 16'h0000;
            prevPeriod_q <= 16'h0000;
            primed_q     <= 1'b0;
            edges_q      <= 2'h0;
            lostSync     <= 1'b0;
        end else begin
            syncPrev_q <= syncIn;
            if (!enable) begin
                cnt_q    <= 16'h0000;
                primed_q <= 1'b0;
                edges_q  <= 2'h0;
            end else if (fallEdge) begin
                cnt_q        <= 16'h0001;
                prevPeriod_q <= cnt_q;
                if (edges_q != 2'h2) edges_q <= edges_q + 2'h1;
                primed_q     <= (edges_q != 2'h0);
            end else if (cnt_q != 16'hffff) begin
                cnt_q <= cnt_q + 16'h0001;
            end
            // Sticky: only reset clears it, the stack must be repowered
            if (enable && tooLate) lostSync <= 1'b1;
        end
    end

    a_late_edge_fault: assert property (@(posedge clk) disable iff (reset)
        enable && tooLate |=> lostSync) else $error("late sync edge not flagged");
endmodule

// ===== verilog/cfp_fault_ctrl.sv
// Fault management core of a synchronous step-down converter.
// Assumes comparator flags and pins arrive asynchronously; swPwm is the modulator request.
`timescale 1ns/1ps
`include "cfp_params.svh"
module cfp_fault_ctrl #(
    parameter int SS_CYC    = `CFP_SS_CYC_DEF,    // Soft-start period in clocks
    parameter int DISCH_CYC = `CFP_DISCH_CYC_DEF  // Overvoltage discharge time in clocks
) (
    input  wire logic               clk,         // System clock 50 MHz
    input  wire logic               reset,       // Synchronous, active high
    input  wire cfp_pkg::cfp_flags_t flagsIn,    // Raw comparator flags and pins
    input  wire logic               swPwm,       // Modulator on-time request
    input  wire logic               syncMode,    // Running from sync clock
    output logic                    highGate,    // High-side switch on
    output logic                    lowGate,     // Low-side switch on
    output logic                    shareOut,    // Share line driven value (0)
    output logic                    shareOen_n,  // Share line drive enable, low drives
    output logic                    hiccupOut,   // In hiccup
    output logic                    lostSyncOut, // Lost sync fault
    output logic                    ssDoneOut    // Soft-start complete
);
    cfp_pkg::cfp_flags_t meta_q, flg_q;
    cfp_pkg::cfp_state_t state_q, state_d;
    logic [1:0]  ocCnt_q;
    logic        cycOc_q;
    logic        pwmPrev_q;
    logic [31:0] tmr_q;
    logic [2:0]  ssCnt_q;
    logic        lostSync;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= '0;
            flg_q  <= '0;
        end else begin
            meta_q <= flagsIn;
            flg_q  <= meta_q;
        end
    end

    cfp_sync_watch u_sync (
        .clk      (clk),
        .reset    (reset),
        .syncIn   (flg_q.syncClk),
        .enable   (syncMode),
        .lostSync (lostSync)
    );

    // Cycle boundary is the rising edge of the modulator request
    wire cycStart  = swPwm & ~pwmPrev_q;
    wire running   = (state_q == cfp_pkg::ST_SOFTSTART) || (state_q == cfp_pkg::ST_RUN);
    wire shareLow  = ~flg_q.shareLine | lostSync;
    wire hsTrip    = flg_q.hsPeak & highGate;
    wire lsTrip    = flg_q.lsOver & ~highGate;
    wire ocEvent   = hsTrip | lsTrip;
    wire cycWasOc  = cycOc_q | ocEvent;
    wire ocThird   = cycStart && cycWasOc && (ocCnt_q == (`CFP_OC_TRIP - 2'h1));
    wire uvTrip    = (state_q == cfp_pkg::ST_RUN) & flg_q.underVolt;
    wire tmrEnd    = (tmr_q == 32'(SS_CYC - 1));
    wire dischEnd  = (tmr_q == 32'(DISCH_CYC - 1));
    // Off state held while over the limit, on-time cut by the peak flag
    wire highReq   = running & swPwm & ~cycOc_q & ~ocEvent & ~flg_q.lsOver & ~shareLow;
    // Negative limit: low side opens when reverse current trips, except in discharge, which holds it on
    wire lowReq    = (running & ~swPwm & ~flg_q.lsNeg & ~shareLow)
                   | (state_q == cfp_pkg::ST_DISCHARGE);

    always_comb begin
        state_d = state_q;
        case (state_q)
            cfp_pkg::ST_SOFTSTART: begin
                if (tmrEnd && ssCnt_q == 3'h0) state_d = cfp_pkg::ST_RUN;
            end
            cfp_pkg::ST_RUN:       state_d = cfp_pkg::ST_RUN;
            cfp_pkg::ST_DISCHARGE: begin
                if (dischEnd) state_d = cfp_pkg::ST_HICCUP;
            end
            cfp_pkg::ST_HICCUP: begin
                if (tmrEnd && ssCnt_q == (`CFP_HICCUP_PERIODS - 3'h1)) state_d = cfp_pkg::ST_SOFTSTART;
            end
            cfp_pkg::ST_THERMAL: begin
                if (!flg_q.overTemp) state_d = cfp_pkg::ST_SOFTSTART;
            end
            default: state_d = cfp_pkg::ST_SOFTSTART;
        endcase
        // Priority: thermal over overvoltage over current and undervoltage faults
        if (state_q != cfp_pkg::ST_THERMAL && flg_q.overTemp) begin
            state_d = cfp_pkg::ST_THERMAL;
        end else if (running && flg_q.overVolt) begin
            state_d = cfp_pkg::ST_DISCHARGE;
        end else if (running && (ocThird || uvTrip)) begin
            state_d = cfp_pkg::ST_HICCUP;
        end
    end

    wire stateChg = (state_d != state_q);

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q   <= cfp_pkg::ST_SOFTSTART;
            tmr_q     <= 32'h0000_0000;
            ssCnt_q   <= 3'h0;
        end else begin
            state_q <= state_d;
            if (stateChg || tmrEnd) tmr_q <= 32'h0000_0000;
            else                    tmr_q <= tmr_q + 32'h0000_0001;
            if (stateChg)                          ssCnt_q <= 3'h0;
            else if (tmrEnd && ssCnt_q != 3'h7)    ssCnt_q <= ssCnt_q + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ocCnt_q   <= 2'h0;
            cycOc_q   <= 1'b0;
            pwmPrev_q <= 1'b0;
        end else begin
            pwmPrev_q <= swPwm;
            if (!running) begin
                ocCnt_q <= 2'h0;
                cycOc_q <= 1'b0;
            end else if (cycStart) begin
                cycOc_q <= 1'b0;
                if (!cycWasOc)                  ocCnt_q <= 2'h0;
                else if (ocCnt_q != `CFP_OC_TRIP) ocCnt_q <= ocCnt_q + 2'h1;
            end else if (ocEvent) begin
                cycOc_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            highGate    <= 1'b0;
            lowGate     <= 1'b0;
            shareOut    <= 1'b0;
            shareOen_n  <= 1'b1;
            hiccupOut   <= 1'b0;
            lostSyncOut <= 1'b0;
            ssDoneOut   <= 1'b0;
        end else begin
            highGate    <= highReq & ~stateChg;
            lowGate     <= lowReq & ~highReq & ~(stateChg && state_d != cfp_pkg::ST_DISCHARGE);
            shareOut    <= 1'b0;
            shareOen_n  <= ~lostSync;
            hiccupOut   <= (state_d == cfp_pkg::ST_HICCUP);
            lostSyncOut <= lostSync;
            ssDoneOut   <= (state_d == cfp_pkg::ST_RUN);
        end
    end

    a_no_shoot_thru: assert property (@(posedge clk) disable iff (reset)
        !(highGate && lowGate)) else $error("both switches on");
    a_neg_limit: assert property (@(posedge clk) disable iff (reset)
        flg_q.lsNeg && state_q != cfp_pkg::ST_DISCHARGE |=> !lowGate) else $error("low side on past negative limit");
    a_ls_hold_off: assert property (@(posedge clk) disable iff (reset)
        flg_q.lsOver |=> !highGate) else $error("on state during overcurrent");
    a_hs_peak_cut: assert property (@(posedge clk) disable iff (reset)
        hsTrip |=> !highGate) else $error("peak flag did not end cycle");
    a_oc_third_hic: assert property (@(posedge clk) disable iff (reset)
        running && ocThird && !flg_q.overTemp && !flg_q.overVolt |=> state_q == cfp_pkg::ST_HICCUP)
        else $error("third overcurrent missed");
    a_clean_clear: assert property (@(posedge clk) disable iff (reset)
        running && cycStart && !cycWasOc |=> ocCnt_q == 2'h0) else $error("counter not cleared");
    a_hiccup_exit: assert property (@(posedge clk) disable iff (reset)
        state_q == cfp_pkg::ST_HICCUP && $past(state_q) != cfp_pkg::ST_HICCUP && !flg_q.overTemp
        |-> ##1 state_q == cfp_pkg::ST_HICCUP) else $error("hiccup left at once");
    // The last discharge cycle hands over to hiccup, where the low side opens
    a_ov_discharge: assert property (@(posedge clk) disable iff (reset)
        state_q == cfp_pkg::ST_DISCHARGE && !dischEnd && !flg_q.overTemp |=> lowGate) else $error("no discharge");
    a_uv_gates_off: assert property (@(posedge clk) disable iff (reset)
        state_q == cfp_pkg::ST_HICCUP |-> ##1 !highGate && !lowGate) else $error("gates on in hiccup");
    a_thermal_stop: assert property (@(posedge clk) disable iff (reset)
        state_q == cfp_pkg::ST_THERMAL |=> !highGate && !lowGate) else $error("switching hot");
    a_share_pull: assert property (@(posedge clk) disable iff (reset)
        lostSync |=> !shareOen_n) else $error("share line not pulled");
    a_share_stop: assert property (@(posedge clk) disable iff (reset)
        shareLow |=> !highGate) else $error("switching with share low");
    a_run_restore: assert property (@(posedge clk) disable iff (reset)
        state_q == cfp_pkg::ST_SOFTSTART && state_d == cfp_pkg::ST_RUN |=> ssDoneOut)
        else $error("run not reported");

    c_hiccup: cover property (@(posedge clk) disable iff (reset) state_q == cfp_pkg::ST_HICCUP);
    c_restart: cover property (@(posedge clk) disable iff (reset)
        state_q == cfp_pkg::ST_HICCUP ##1 state_q == cfp_pkg::ST_SOFTSTART);
    c_discharge: cover property (@(posedge clk) disable iff (reset) state_q == cfp_pkg::ST_DISCHARGE);
    c_lost_sync: cover property (@(posedge clk) disable iff (reset) $rose(lostSync));
endmodule

// ===== tb/cfp_peer_model.sv
// Stacked peer converter seen through the shared sync and share lines.
// Assumes commands arrive from the bench at rising clock edges.
`timescale 1ns/1ps
module cfp_peer_model #(
    parameter int HALF = 20         // Sync half period in clocks
) (
    input  wire logic clk,          // System clock
    input  wire logic syncRun,      // Sync clock running
    input  wire logic pullLow,      // Peer pulls share line low
    input  wire logic dutOen_n,     // Block share drive enable
    input  wire logic dutOut,       // Block share drive value
    output logic      syncClk,      // Sync clock level
    output logic      shareLine,    // Resolved share line
    output logic      halted        // Peer switching stopped
);
    int cnt = 0;
    initial syncClk = 1'b1;
    // Pull-up on the share line, so a released line reads high
    assign shareLine = !(pullLow || (!dutOen_n && !dutOut));
    assign halted = !shareLine;
    always @(posedge clk) begin
        cnt <= syncRun ? (cnt + 1) % HALF : 0;
        // A stopped sync clock stands high, giving no falling edge
        if (!syncRun)
            syncClk <= 1'b1;
        else if (cnt == HALF - 1)
            syncClk <= !syncClk;
    end
endmodule

// ===== tb/cfp_fault_ctrl_test.sv
// Self-checking bench for the converter fault protection core.
// Assumes the peer model drives the sync and share lines.
`timescale 1ns/1ps
module cfp_fault_ctrl_test;
    localparam int SS = 16;
    localparam int HIC = 7 * SS;
    logic                clk = 1'b0;
    logic                reset = 1'b1;
    logic                swPwm = 1'b0;
    logic                syncMode = 1'b0;
    logic                syncRun = 1'b0;
    logic                pullLow = 1'b0;
    logic [3:0]          pwmCnt = 4'h0;
    logic [5:0]          fl = 6'h00;  // hsPeak lsOver lsNeg overVolt underVolt overTemp
    logic                syncW, shareW, highGate, lowGate, shareOut, shareOen_n, hiccupOut, lostSyncOut, ssDoneOut;
    cfp_pkg::cfp_flags_t flagsIn;
    wire                 peerHalt;
    int                  n_mismatch = 0;
    int                  n_compared = 0;
    int                  cyc = 0;
    int                  n;
    wire [4:0]           obs = {hiccupOut, ssDoneOut, lostSyncOut, highGate, lowGate};
    assign flagsIn = {fl, syncW, shareW};
    cfp_fault_ctrl #(.SS_CYC(SS), .DISCH_CYC(8)) i_cfp_fault_ctrl (
        .clk(clk), .reset(reset), .flagsIn(flagsIn), .swPwm(swPwm), .syncMode(syncMode),
        .highGate(highGate), .lowGate(lowGate), .shareOut(shareOut), .shareOen_n(shareOen_n),
        .hiccupOut(hiccupOut), .lostSyncOut(lostSyncOut), .ssDoneOut(ssDoneOut));
    cfp_peer_model i_cfp_peer_model (.clk(clk), .syncRun(syncRun), .pullLow(pullLow), .dutOen_n(shareOen_n),
        .dutOut(shareOut), .syncClk(syncW), .shareLine(shareW), .halted(peerHalt));
    initial forever #10 clk = !clk;
    // Modulator: 16-clock cycle, on for 10 clocks
    always @(posedge clk) begin
        pwmCnt <= pwmCnt + 4'h1;
        swPwm <= pwmCnt < 4'ha;
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic wait_bit(input int b, input logic v, input int lim);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (obs[b] !== v && n < lim);
        chk(v, obs[b]);
    endtask
    task automatic count_high(input int b, input int len);
        n = 0;
        repeat (len) begin
            @(negedge clk);
            n += (obs[b] !== 1'b0);
        end
    endtask
    task automatic at_cnt(input logic [3:0] v);
        do @(negedge clk); while (pwmCnt != v);
        @(posedge clk);
    endtask
    task automatic run_up();
        @(posedge clk);
        reset <= 1'b1;
        {fl, syncMode, syncRun, pullLow} <= '0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        wait_bit(3, 1'b1, SS + 12);
    endtask
    task automatic t_start();
        run_up();
        chk(1, n >= SS - 2 && n <= SS + 6);
        chk(1, shareOen_n);
        $display("start done");
    endtask
    task automatic t_oc();
        run_up();
        at_cnt(4'hb);
        fl[4] <= 1'b1;
        count_high(1, 20);
        chk(0, n);
        wait_bit(4, 1'b1, 40);
        @(posedge clk);
        fl[4] <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n += (highGate !== 1'b0) ? 1000 : 1;
        end while (hiccupOut === 1'b1 && n < 300);
        chk(HIC, n);
        wait_bit(3, 1'b1, SS + 12);
        at_cnt(4'hb);
        fl[4] <= 1'b1;
        wait_bit(4, 1'b1, 60);
        $display("overcurrent done");
    endtask
    task automatic t_clean();
        run_up();
        repeat (2) begin
            at_cnt(4'hb);
            fl[4] <= 1'b1;
            at_cnt(4'hb);
            fl[4] <= 1'b0;
            at_cnt(4'hb);
        end
        count_high(4, 40);
        chk(0, n);
        $display("clean cycle done");
    endtask
    task automatic t_hs();
        run_up();
        wait_bit(1, 1'b1, 20);
        // Raise the peak flag early in the on time so the cut is not the natural end
        at_cnt(4'h1);
        fl[5] <= 1'b1;
        wait_bit(1, 1'b0, 4);
        chk(1, swPwm);
        wait_bit(4, 1'b1, 60);
        $display("peak current done");
    endtask
    task automatic t_ov();
        run_up();
        @(posedge clk);
        fl[2] <= 1'b1;
        wait_bit(0, 1'b1, 6);
        chk(0, highGate);
        wait_bit(4, 1'b1, 20);
        $display("overvoltage done");
    endtask
    task automatic t_uv();
        run_up();
        @(posedge clk);
        fl[1] <= 1'b1;
        wait_bit(4, 1'b1, 8);
        chk(0, highGate | lowGate);
        // Undervoltage still high: soft-start must run to the end before it counts
        wait_bit(3, 1'b1, HIC + SS + 12);
        wait_bit(4, 1'b1, 4);
        $display("undervoltage done");
    endtask
    task automatic t_therm();
        run_up();
        @(posedge clk);
        fl[0] <= 1'b1;
        wait_bit(3, 1'b0, 6);
        count_high(1, 40);
        chk(0, n);
        @(posedge clk);
        fl[0] <= 1'b0;
        wait_bit(3, 1'b1, SS + 12);
        $display("thermal done");
    endtask
    task automatic t_share();
        run_up();
        @(posedge clk);
        pullLow <= 1'b1;
        repeat (4) @(posedge clk);
        count_high(1, 40);
        chk(0, n);
        @(posedge clk);
        pullLow <= 1'b0;
        wait_bit(1, 1'b1, 40);
        $display("share line done");
    endtask
    task automatic t_sync();
        run_up();
        @(posedge clk);
        {syncMode, syncRun} <= 2'h3;
        count_high(2, 200);
        chk(0, n);
        // A short pause keeps the gap under the previous period plus the late limit
        @(posedge clk);
        syncRun <= 1'b0;
        repeat (20) @(posedge clk);
        syncRun <= 1'b1;
        count_high(2, 120);
        chk(0, n);
        @(posedge clk);
        syncRun <= 1'b0;
        repeat (100) @(posedge clk);
        syncRun <= 1'b1;
        wait_bit(2, 1'b1, 100);
        chk(0, shareOen_n);
        chk(0, shareOut);
        chk(1, peerHalt);
        count_high(1, 30);
        chk(0, n);
        $display("lost sync done");
    endtask
    task automatic t_neg();
        run_up();
        wait_bit(0, 1'b1, 24);
        @(posedge clk);
        fl[3] <= 1'b1;
        repeat (3) @(posedge clk);
        count_high(0, 40);
        chk(0, n);
        @(posedge clk);
        fl[3] <= 1'b0;
        wait_bit(0, 1'b1, 24);
        $display("negative limit done");
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        t_start();
        t_oc();
        t_clean();
        t_hs();
        t_neg();
        t_ov();
        t_uv();
        t_therm();
        t_share();
        t_sync();
        finish_test();
    end
endmodule
